// *** pkg/bsp_pkg.sv ***
// Constants and types shared by the boundary scan path
`default_nettype none
package bsp_pkg;

    // ****************************************
    // Register geometry and reset values
    // ****************************************
    localparam int         INSTR_W       = 8;
    localparam logic [7:0] INSTR_RESET   = 8'h81;
    localparam logic [7:0] INSTR_CAPTURE = 8'h81;
    localparam int         PARITY_BIT    = 7;
    localparam int         CHAIN_W       = 52;
    localparam int         EN_LO         = 48;
    localparam int         EN_HI         = 51;
    localparam int         A_LO          = 18;
    localparam int         A_HI          = 35;
    localparam int         B_LO          = 0;
    localparam int         B_HI          = 17;
    localparam int         DATA_W        = 18;
    localparam int         ID_W          = 32;
    // Arbitrary identification value
    localparam logic [31:0] ID_VALUE     = 32'h0000_0001;
    localparam int         SYNC_STAGES   = 2;

    // ****************************************
    // Opcodes, bit 7 carries even parity
    // ****************************************
    localparam logic [7:0] OP_EXTEST  = 8'h00;
    localparam logic [7:0] OP_IDCODE  = 8'h81;
    localparam logic [7:0] OP_SAMPLE  = 8'h82;
    localparam logic [7:0] OP_HIGHZ   = 8'h06;
    localparam logic [7:0] OP_CLAMP   = 8'h87;
    localparam logic [7:0] OP_RUNT    = 8'h09;
    localparam logic [7:0] OP_READBN  = 8'h0a;
    localparam logic [7:0] OP_READBT  = 8'h8b;
    localparam logic [7:0] OP_CELLTST = 8'h0c;
    localparam logic [7:0] OP_TOPHIP  = 8'h8d;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IN, ST_CAP_IN, ST_SH_IN, ST_EX1_IN,
        ST_PAU_IN, ST_EX2_IN, ST_UPD_IN
    } bsp_tap_t;

    typedef enum logic [1:0] {SEL_BND, SEL_BYP, SEL_ID} bsp_sel_t;

    typedef struct packed {
        logic     test_mode;
        bsp_sel_t sel;
        logic     cap_pins;
        logic     upd;
        logic     highz;
        logic     toggle;
    } bsp_dec_t;

    // Index 1 is group 2, index 0 group 1
    typedef struct packed {
        logic [1:0]        output_enable_n;
        logic [1:0]        flow_select;
        logic [1:0]        a_to_b_store_clock;
        logic [1:0]        b_to_a_store_clock;
        logic [1:0]        a_to_b_source_select;
        logic [1:0]        b_to_a_source_select;
        logic [DATA_W-1:0] a_data;
        logic [DATA_W-1:0] b_data;
    } bsp_pins_t;

    typedef struct packed {
        logic              test_mode;
        logic [1:0]        a_side_drive_enable;
        logic [1:0]        b_side_drive_enable;
        logic [DATA_W-1:0] a_out;
        logic [DATA_W-1:0] b_out;
    } bsp_apply_t;

endpackage
`default_nettype wire

// *** hdl/bsp_sync.sv ***
// Two flip-flop level synchroniser
`default_nettype none
module bsp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i)
    begin
        meta_q <= d_i;
        q_o    <= meta_q;
    end

endmodule
`default_nettype wire

// *** hdl/bsp_top.sv ***
// Boundary scan path: test port controller, instruction and data registers
//
// Overview of operation
// - Data capture loads selected register on exit edge
// - Shift-DR enables TDO on falling edge, LSB
// - Data shifts each rising edge after entry
// - First data exit floats TDO on falling edge
// - Return to data shift without recapture
// - Data pause holds partial contents
// - Data update loads shadow on falling edge
// - Instruction capture loads fixed 10000001
// - Instruction shift enables TDO, drives LSB
// - Instruction shifts each rising edge after entry
// - Instruction exit floats TDO, no recapture
// - Instruction pause holds partial contents
// - Instruction update on falling edge, takes effect
// - Shadow latches except bypass and identification
// - Eight-bit instruction decodes mode, register, source
// - Bit 7 even parity, unknown opcodes bypass
// - Reset forces instruction to 10000001
// - Boundary chain holds 52 cells
// - Instruction picks capture source, idle changes
// - Reset clears enable cells 51 to 48
// - Enable cells capture decoded enable equations
// - Chain order 51 down to 0
// - State advances on TMS at rising edge
// - TMS high five cycles reaches reset
// - Bypass captures zero
`default_nettype none
module bsp_top (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            tck_i,
    input  wire logic            tms_i,
    input  wire logic            tdi_i,
    output logic                 tdo_o,
    output logic                 tdo_oe_o,
    input  wire bsp_pkg::bsp_pins_t  pins_i,
    output bsp_pkg::bsp_apply_t      apply_o
);
    import bsp_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic bsp_tap_t tap_next(input bsp_tap_t s, input logic tms);
        unique case (s)
            ST_RESET:  tap_next = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   tap_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_next = tms ? ST_SEL_IN : ST_CAP_DR;
            ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IN: tap_next = tms ? ST_RESET  : ST_CAP_IN;
            ST_CAP_IN: tap_next = tms ? ST_EX1_IN : ST_SH_IN;
            ST_SH_IN:  tap_next = tms ? ST_EX1_IN : ST_SH_IN;
            ST_EX1_IN: tap_next = tms ? ST_UPD_IN : ST_PAU_IN;
            ST_PAU_IN: tap_next = tms ? ST_EX2_IN : ST_PAU_IN;
            ST_EX2_IN: tap_next = tms ? ST_UPD_IN : ST_SH_IN;
            ST_UPD_IN: tap_next = tms ? ST_SEL_DR : ST_IDLE;
            default:   tap_next = ST_RESET;
        endcase
    endfunction

    // Opcode to operation; bad parity or unknown code acts as bypass
    function automatic bsp_dec_t decode(input logic [7:0] op);
        bsp_dec_t d;
        d = '{test_mode: 1'b0, sel: SEL_BYP, cap_pins: 1'b0, upd: 1'b0,
              highz: 1'b0, toggle: 1'b0};
        if (^op == 1'b0)
        begin
            unique case (op)
                OP_EXTEST:  d = '{1'b1, SEL_BND, 1'b1, 1'b1, 1'b0, 1'b0};
                OP_IDCODE:  d.sel = SEL_ID;
                OP_SAMPLE:  d = '{1'b0, SEL_BND, 1'b1, 1'b1, 1'b0, 1'b0};
                OP_HIGHZ:   d = '{1'b1, SEL_BYP, 1'b0, 1'b0, 1'b1, 1'b0};
                OP_CLAMP:   d.test_mode = 1'b1;
                OP_RUNT:    d.test_mode = 1'b1;
                OP_READBN:  d = '{1'b0, SEL_BND, 1'b0, 1'b0, 1'b0, 1'b0};
                OP_READBT:  d = '{1'b1, SEL_BND, 1'b0, 1'b0, 1'b0, 1'b0};
                OP_CELLTST: d = '{1'b0, SEL_BND, 1'b0, 1'b1, 1'b0, 1'b0};
                OP_TOPHIP:  d = '{1'b1, SEL_BYP, 1'b0, 1'b0, 1'b0, 1'b1};
                default:    d.sel = SEL_BYP;
            endcase
        end
        return d;
    endfunction

    // ****************************************
    // Reset into the test clock domain
    // ****************************************
    logic tck_rst;

    bsp_sync #(.W(1)) u_rst_sync (
        .clk_i (tck_i),
        .d_i   (rst_i),
        .q_o   (tck_rst)
    );

    // ****************************************
    // Pin sampling for external capture
    // ****************************************
    bsp_pins_t pins_s;

    bsp_sync #(.W($bits(bsp_pins_t))) u_pin_sync (
        .clk_i (tck_i),
        .d_i   (pins_i),
        .q_o   (pins_s)
    );

    wire [1:0] a_en_cap = ~pins_s.output_enable_n & ~pins_s.flow_select;
    wire [1:0] b_en_cap = ~pins_s.output_enable_n &  pins_s.flow_select;

    // Cell map 51..0 from serial input toward TDO
    wire [CHAIN_W-1:0] pin_vec = {b_en_cap, a_en_cap,
                                  pins_s.flow_select, pins_s.output_enable_n,
                                  pins_s.a_to_b_store_clock, pins_s.b_to_a_store_clock,
                                  pins_s.a_to_b_source_select, pins_s.b_to_a_source_select,
                                  pins_s.a_data, pins_s.b_data};

    // ****************************************
    // Controller state
    // ****************************************
    bsp_tap_t st_q;
    bsp_tap_t st_d;

    assign st_d = tap_next(st_q, tms_i);

    always_ff @(posedge tck_i)
    begin
        if (tck_rst)
            st_q <= ST_RESET;
        else
            st_q <= st_d;
    end

    wire in_reset = tck_rst || (st_q == ST_RESET);

    // ****************************************
    // Instruction register
    // ****************************************
    logic [INSTR_W-1:0] instr_sh_q;
    logic [INSTR_W-1:0] instr_q;
    bsp_dec_t           dec;

    assign dec = decode(instr_q);

    always_ff @(posedge tck_i)
    begin
        if (st_q == ST_CAP_IN)
            instr_sh_q <= INSTR_CAPTURE;
        else if (st_q == ST_SH_IN)
            instr_sh_q <= {tdi_i, instr_sh_q[INSTR_W-1:1]};
    end

    // Shadow loads on the falling edge; pause and exits leave it alone
    always_ff @(negedge tck_i)
    begin
        if (in_reset)
            instr_q <= INSTR_RESET;
        else if (st_q == ST_UPD_IN)
            instr_q <= instr_sh_q;
    end

    // ****************************************
    // Data registers
    // ****************************************
    logic [CHAIN_W-1:0] bnd_sh_q;
    logic [CHAIN_W-1:0] bnd_shadow_q;
    logic               byp_q;
    logic [ID_W-1:0]    id_q;

    wire cap_dr = (st_q == ST_CAP_DR);
    wire sh_dr  = (st_q == ST_SH_DR);
    wire [CHAIN_W-1:0] bnd_src = dec.cap_pins ? pin_vec : bnd_shadow_q;

    always_ff @(posedge tck_i)
    begin
        if (in_reset)
            bnd_sh_q[EN_HI:EN_LO] <= '0;
        else if (cap_dr && dec.sel == SEL_BND)
            bnd_sh_q <= bnd_src;
        else if (sh_dr && dec.sel == SEL_BND)
            bnd_sh_q <= {tdi_i, bnd_sh_q[CHAIN_W-1:1]};
    end

    always_ff @(posedge tck_i)
    begin
        if (cap_dr)
            byp_q <= 1'b0;
        else if (sh_dr)
            byp_q <= tdi_i;
    end

    always_ff @(posedge tck_i)
    begin
        if (cap_dr && dec.sel == SEL_ID)
            id_q <= ID_VALUE;
        else if (sh_dr && dec.sel == SEL_ID)
            id_q <= {tdi_i, id_q[ID_W-1:1]};
    end

    // Boundary shadow; idle toggling drives the output cells
    always_ff @(negedge tck_i)
    begin
        if (in_reset)
            bnd_shadow_q[EN_HI:EN_LO] <= '0;
        else if (st_q == ST_UPD_DR && dec.sel == SEL_BND && dec.upd)
            bnd_shadow_q <= bnd_sh_q;
        else if (st_q == ST_IDLE && dec.toggle)
            bnd_shadow_q[A_HI:B_LO] <= ~bnd_shadow_q[A_HI:B_LO];
    end

    // ****************************************
    // Serial output
    // ****************************************
    wire dr_lsb = (dec.sel == SEL_BND) ? bnd_sh_q[0] :
                  (dec.sel == SEL_ID)  ? id_q[0] : byp_q;
    wire oe_d   = sh_dr || (st_q == ST_SH_IN);
    wire tdo_d  = (st_q == ST_SH_IN) ? instr_sh_q[0] : dr_lsb;

    // Output changes only on the falling edge
    always_ff @(negedge tck_i)
    begin
        if (in_reset)
        begin
            tdo_oe_o <= 1'b0;
            tdo_o    <= 1'b0;
        end
        else
        begin
            tdo_oe_o <= oe_d;
            tdo_o    <= tdo_d;
        end
    end

    // ****************************************
    // Applied state toward the system clock
    // ****************************************
    bsp_apply_t apply_d;
    bsp_apply_t apply_tck_q;
    logic       apply_tgl_q;

    assign apply_d.test_mode           = dec.test_mode;
    assign apply_d.a_side_drive_enable = dec.highz ? 2'h0 : bnd_shadow_q[49:48];
    assign apply_d.b_side_drive_enable = dec.highz ? 2'h0 : bnd_shadow_q[51:50];
    assign apply_d.a_out               = bnd_shadow_q[A_HI:A_LO];
    assign apply_d.b_out               = bnd_shadow_q[B_HI:B_LO];

    // Word held stable while a toggle announces it
    always_ff @(posedge tck_i)
    begin
        if (tck_rst)
        begin
            apply_tck_q <= '0;
            apply_tgl_q <= 1'b0;
        end
        else if (apply_d != apply_tck_q)
        begin
            apply_tck_q <= apply_d;
            apply_tgl_q <= ~apply_tgl_q;
        end
    end

    logic tgl_s;
    logic tgl_seen_q;

    bsp_sync #(.W(1)) u_tgl_sync (
        .clk_i (clk_i),
        .d_i   (apply_tgl_q),
        .q_o   (tgl_s)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tgl_seen_q <= 1'b0;
            apply_o    <= '0;
        end
        else
        begin
            tgl_seen_q <= tgl_s;
            if (tgl_s != tgl_seen_q)
                apply_o <= apply_tck_q;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    instr_capture_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q == ST_CAP_IN |=> instr_sh_q == INSTR_CAPTURE)
        else $error("instruction capture value wrong");

    instr_shift_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q == ST_SH_IN |=> instr_sh_q == {$past(tdi_i), $past(instr_sh_q[7:1])})
        else $error("instruction shift wrong");

    instr_hold_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q == ST_PAU_IN ##1 st_q == ST_PAU_IN |-> $stable(instr_sh_q))
        else $error("instruction pause lost data");

    dr_pause_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q inside {ST_PAU_DR, ST_EX2_DR} |=> $stable(bnd_sh_q) && $stable(id_q))
        else $error("data pause lost data");

    tdo_enable_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q == ST_SH_DR |-> tdo_oe_o && tdo_o == dr_lsb)
        else $error("TDO not driving in data shift");

    tdo_float_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q inside {ST_EX1_DR, ST_EX1_IN} |-> !tdo_oe_o)
        else $error("TDO not floated in exit");

    tdo_instr_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q == ST_SH_IN |-> tdo_oe_o && tdo_o == instr_sh_q[0])
        else $error("TDO wrong in instruction shift");

    instr_update_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q == ST_UPD_IN |=> instr_q == $past(instr_sh_q))
        else $error("instruction not updated");

    tms_reset_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        tms_i [*5] |=> st_q == ST_RESET)
        else $error("five TMS highs did not reset");

    bypass_zero_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q == ST_CAP_DR |=> byp_q == 1'b0)
        else $error("bypass did not capture zero");

    enable_reset_a: assert property (@(posedge tck_i) disable iff (tck_rst)
        st_q == ST_RESET |=> bnd_sh_q[EN_HI:EN_LO] == 4'h0 && instr_q == INSTR_RESET)
        else $error("reset values wrong");

endmodule
`default_nettype wire

// *** dv/bsp_jtag_ctl.sv ***
// Behavioural scan controller that drives the test port from outside
`default_nettype none
module bsp_jtag_ctl (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    logic oe_ok;

    // ****************************************
    // Test clock stands still outside frames
    // ****************************************
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        oe_ok = 1'b1;
    end

    // One tck period: mode and data set well before the rising edge
    task automatic step(input logic m, input logic d, output logic so, output logic soe);
        tms_o = m;
        tdi_o = d;
        #15;
        so    = tdo_i;
        soe   = tdo_oe_i;
        tck_o = 1'b1;
        #16;
        tck_o = 1'b0;
        #1;
    endtask

    // Released data line rests high
    task automatic walk(input logic m);
        logic so;
        logic soe;
        step(m, 1'b1, so, soe);
    endtask

    // Five ones reach reset, then park in idle
    task automatic tap_reset();
        repeat (5) walk(1'b1);
        walk(1'b0);
    endtask

    // Full scan from idle back to idle, optional pause after pause_at bits
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        input int pause_at, output logic [63:0] dout);
        logic so;
        logic soe;
        dout = '0;
        walk(1'b1);
        if (ir)
            walk(1'b1);
        walk(1'b0);
        walk(1'b0);
        for (int i = 0; i < n; i++)
        begin
            step((i == n - 1) || (i == pause_at - 1), din[i], so, soe);
            dout[i] = so;
            if (soe !== 1'b1)
                oe_ok = 1'b0;
            if (i == pause_at - 1)
            begin
                repeat (3)
                begin
                    step(1'b0, 1'b1, so, soe);
                    if (soe !== 1'b0)
                        oe_ok = 1'b0;
                end
                walk(1'b1);
                walk(1'b0);
            end
        end
        walk(1'b1);
        walk(1'b0);
        walk(1'b0);
        walk(1'b0);
    endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the boundary scan path
`default_nettype none
module tb;
    import bsp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_i;
    logic       rst_i;
    logic       tck;
    logic       tms;
    logic       tdi;
    logic       tdo;
    logic       tdo_oe;
    bsp_pins_t  pins;
    bsp_apply_t apply;
    int         err_count;
    int         samples_checked;

    bsp_top DUT (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tck_i    (tck),
        .tms_i    (tms),
        .tdi_i    (tdi),
        .tdo_o    (tdo),
        .tdo_oe_o (tdo_oe),
        .pins_i   (pins),
        .apply_o  (apply)
    );

    bsp_jtag_ctl u_ctl (
        .tck_o    (tck),
        .tms_o    (tms),
        .tdi_o    (tdi),
        .tdo_i    (tdo),
        .tdo_oe_i (tdo_oe)
    );

    // ****************************************
    // Clock, checking and closing
    // ****************************************
    initial
    begin
        clk_i = 1'b0;
    end

    always #2.5 clk_i = ~clk_i;

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Pin snapshot as the chain should hold it after capture
    function automatic logic [51:0] exp_cap(input bsp_pins_t p);
        logic [1:0] en_n;
        logic [1:0] dir;
        en_n = p.output_enable_n;
        dir  = p.flow_select;
        return {~en_n[1] & dir[1], ~en_n[0] & dir[0], ~en_n[1] & ~dir[1], ~en_n[0] & ~dir[0],
                dir, en_n, p.a_to_b_store_clock, p.b_to_a_store_clock,
                p.a_to_b_source_select, p.b_to_a_source_select, p.a_data, p.b_data};
    endfunction

    initial
    begin
        #250000;
        err_count++;
        wrap_up();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [63:0] got;
        logic [63:0] pat;
        logic [51:0] shadow;
        logic [7:0]  byp_ops [6];
        err_count       = 0;
        samples_checked = 0;
        rst_i           = 1'b1;
        pins            = '0;
        byp_ops         = '{8'h03, 8'h84, 8'h01, 8'h8e, OP_CLAMP, OP_RUNT};
        void'($urandom(32'h9f54));
        // Test clock must see the reset as well
        fork
            repeat (10) @(posedge clk_i);
            repeat (3) u_ctl.walk(1'b1);
        join
        @(posedge clk_i);
        rst_i <= 1'b0;
        u_ctl.tap_reset();
        u_ctl.scan(1'b1, 8, 64'h81, 0, got);
        check("ir_capture", 64'(got[7:0]), 64'(INSTR_CAPTURE));
        u_ctl.scan(1'b0, 32, {$urandom(), $urandom()}, 0, got);
        check("id_after_reset", 64'(got[31:0]), 64'(ID_VALUE));
        // Bypass opcodes, wrong parity, unbuilt, bypass-path test modes
        foreach (byp_ops[k])
        begin
            u_ctl.scan(1'b1, 8, 64'(byp_ops[k]), 0, got);
            pat = {$urandom(), $urandom()};
            u_ctl.scan(1'b0, 8, pat, 0, got);
            check("bypass_path", 64'(got[7:0]), 64'({pat[6:0], 1'b0}));
        end
        // Sample pins, shift a pattern with a pause in the middle
        @(posedge clk_i);
        pins <= bsp_pins_t'(48'({$urandom(), $urandom()}));
        u_ctl.scan(1'b1, 8, 64'(OP_SAMPLE), 0, got);
        pat = {$urandom(), $urandom()};
        pat[51:48] = 4'b1011;
        u_ctl.scan(1'b0, CHAIN_W, pat, 20, got);
        check("pin_capture", 64'(got[51:0]),
              64'(exp_cap(pins)));
        shadow = pat[51:0];
        u_ctl.scan(1'b1, 8, 64'(OP_READBN), 3, got);
        check("ir_pause", 64'(got[7:0]), 64'(INSTR_CAPTURE));
        u_ctl.scan(1'b0, CHAIN_W, {$urandom(), $urandom()}, 0, got);
        check("shadow_read", 64'(got[51:0]), 64'(shadow));
        check("tdo_enable", 64'(u_ctl.oe_ok), 64'h1);
        // Drive the stored pattern out in test mode
        u_ctl.scan(1'b1, 8, 64'(OP_EXTEST), 0, got);
        repeat (12) @(posedge clk_i);
        check("extest_apply", 64'(apply), 64'({1'b1, shadow[49:48], shadow[51:50],
              shadow[35:18], shadow[17:0]}));
        // High impedance forces every drive enable off in test mode
        u_ctl.scan(1'b1, 8, 64'(OP_HIGHZ), 0, got);
        repeat (12) @(posedge clk_i);
        check("highz_apply", 64'({apply.test_mode, apply.a_side_drive_enable,
              apply.b_side_drive_enable}), 64'h10);
        // Return through reset by holding mode high
        u_ctl.tap_reset();
        repeat (12) @(posedge clk_i);
        check("reset_mode", 64'(apply.test_mode), 64'h0);
        u_ctl.scan(1'b0, 32, {$urandom(), $urandom()}, 0, got);
        check("id_after_tms", 64'(got[31:0]), 64'(ID_VALUE));
        // Enable cells were cleared, so test mode drives nothing
        u_ctl.scan(1'b1, 8, 64'(OP_READBT), 0, got);
        repeat (12) @(posedge clk_i);
        check("cleared_enables", 64'({apply.test_mode, apply.a_side_drive_enable,
              apply.b_side_drive_enable}), 64'h10);
        wrap_up();
    end
endmodule
`default_nettype wire
